// ---- src/gsr_pkg.sv ----
// Package for the gauge status readback block: frame layout, select
// codes, flag positions and the carrier type for live gauge state.
// Assumes one 20 MHz system clock; serial pins arrive asynchronously.
package gsr_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          FRAME_BITS    = 16;
  localparam int          CNT_W         = 4;
  localparam logic [3:0]  CNT_ZERO      = 4'h0;
  localparam int          CMD_ADDR_LSB  = 13;
  localparam logic [2:0]  SEL_CMD_ADDR  = 3'h0;
  localparam int          SEL_LSB       = 8;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;

  // ----------------------------------------------------------------
  // Status select codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  SEL_RESET     = 4'h0;
  localparam logic [3:0]  SEL_POS0      = 4'hc;
  localparam logic [3:0]  SEL_POS1      = 4'hd;

  // ----------------------------------------------------------------
  // Sticky flag positions
  // ----------------------------------------------------------------
  localparam int FLAG_N    = 9;
  localparam int FL_HIGH   = 0;
  localparam int FL_LOW    = 1;
  localparam int FL_FAULT  = 2;
  localparam int FL_SHIFT0 = 3;
  localparam int FL_SHIFT1 = 4;
  localparam int FL_ZERO0  = 5;
  localparam int FL_ZERO1  = 6;
  localparam int FL_HEAT0  = 7;
  localparam int FL_HEAT1  = 8;
  localparam logic [8:0] FLAGS_RESET = 9'h000;

  // ----------------------------------------------------------------
  // Live state of one gauge, from the motion logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        enabled;
    logic        heading;
    logic        against_cmd;
    logic        home_side;
    logic        off_target;
    logic        homing;
    logic [11:0] position;
    logic [7:0]  velocity;
  } gsr_gauge_t;

endpackage : gsr_pkg

// ---- src/gsr_sync.sv ----
// Two-stage synchroniser, one stage pair per bit.
// Assumes inputs are asynchronous to clk; ce freezes the stages.
`timescale 1ns/1ps
`default_nettype none
module gsr_sync
  import gsr_pkg::*;
#(
  parameter int W = 3
)(
  // Clock and control
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_comb
      begin
        meta_next[i] = ce ? d[i] : meta_reg[i];
        q_next[i]    = ce ? meta_reg[i] : q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta_reg <= '1;
      q        <= '1;
    end
    else
    begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end

endmodule : gsr_sync
`default_nettype wire

// ---- src/gsr_flag_bank.sv ----
// Bank of sticky flags: a set pulse wins over a clear in the same cycle.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gsr_flag_bank
  import gsr_pkg::*;
#(
  parameter int W = FLAG_N
)(
  // Clock and control
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  // Events
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output var  logic [W-1:0] q
);

  logic [W-1:0] q_next;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_flag
      always_comb
      begin
        if (!ce)
          q_next[i] = q[i];
        else if (set[i])
          q_next[i] = 1'b1;
        else if (clr[i])
          q_next[i] = 1'b0;
        else
          q_next[i] = q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!nrst)
      q <= W'(FLAGS_RESET);
    else
      q <= q_next;
  end

endmodule : gsr_flag_bank
`default_nettype wire

// ---- src/gsr_status_readback.sv ----
// Serial status readback of a dual gauge driver: frame capture, status
// select, status word assembly, sticky faults and echo on the output.
// Assumes serial pins are asynchronous and sampled by the 20 MHz clock;
// live gauge state and event pulses come from logic on the same clock.
//
// Overview of operation
// - Chip select low loads selected status word; output sends it MSB first.
// - On chip select high accept frame only if bit count nonzero, multiple 16.
// - With chip select high the output floats and status may update.
// - Supply faults stay latched until device status word was sent in a frame.
// - Frame of bad length clears nothing; faults are sent again later.
// - Pointer bits are live, sampled when the status word is loaded.
// - After sixteen bits the output echoes input bits received since select.
// - Last accepted four-bit select field fixes the word type until reset.
// - Select field with top bit zero chooses the device status word.
// - 10xx accumulator, 1100 gauge 0, 1101 gauge 1, 111x both velocities.
// - Bits 15 and 14 give gauge 1 and gauge 0 heading.
// - Bits 13 and 12 give gauge 1 and gauge 0 home side.
// - Bits 11 and 10 are one while the gauge is off target.
// - Bit 9 flags supply high since last frame; it shuts all drivers.
// - Bit 8 flags supply low since last frame; drivers stay on.
// - Bit 7 is one when clock calibration fell out of tolerance.
// - Bit 6 is one after supply low or supply high since last frame.
// - Bits 5 and 4 flag gauge 1 and gauge 0 moved since last command.
// - Bits 3 and 2 stay one while homing, until frame after zero found.
// - Bits 1 and 0 flag overheat, disable that gauge, hold until re-enabled.
`timescale 1ns/1ps
`default_nettype none
module gsr_status_readback
  import gsr_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  // Serial pins
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        si,
  output var  logic        so,
  output var  logic        so_oe_n,
  // Live state from the motion and return-home logic
  input  wire gsr_gauge_t  gauge0,
  input  wire gsr_gauge_t  gauge1,
  input  wire logic [14:0] rtz_acc,
  input  wire logic        rtz_active,
  input  wire logic        cal_fault,
  // Event pulses, one clock each
  input  wire logic        supply_high_evt,
  input  wire logic        supply_low_evt,
  input  wire logic [1:0]  moved_evt,
  input  wire logic [1:0]  zero_found_evt,
  input  wire logic [1:0]  return_home_off,
  input  wire logic [1:0]  overheat_evt,
  input  wire logic [1:0]  gauge_reenable,
  // Accepted frame and control results
  output var  logic [15:0] frame_word,
  output var  logic        frame_strobe,
  output var  logic [3:0]  status_select,
  output var  logic        drivers_off,
  output var  logic [1:0]  gauge_off
);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic       cs_s;
  logic       sclk_s;
  logic       si_s;
  logic       sclk_d_reg;
  logic       sclk_d_next;
  logic       sclk_rise;
  logic       sclk_fall;

  gsr_sync #(.W(3)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    // Serial clock enters inverted so its reset value matches idle low
    .d    ({cs_n, !sclk, si}),
    .q    (pins_s)
  );

  assign cs_s      = pins_s[2];
  assign sclk_s    = !pins_s[1];
  assign si_s      = pins_s[0];
  assign sclk_rise = ce && sclk_s && !sclk_d_reg;
  assign sclk_fall = ce && !sclk_s && sclk_d_reg;

  always_comb
  begin
    sclk_d_next = ce ? sclk_s : sclk_d_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      sclk_d_reg <= 1'b0;
    else
      sclk_d_reg <= sclk_d_next;
  end

  // ----------------------------------------------------------------
  // Sticky flags and status word assembly
  // ----------------------------------------------------------------
  logic [FLAG_N-1:0] flags;
  logic [FLAG_N-1:0] flag_set;
  logic [FLAG_N-1:0] flag_clr;
  logic [15:0]       dev_word;
  logic [15:0]       status_word;

  always_comb
  begin
    flag_set = '0;
    flag_set[FL_HIGH]  = supply_high_evt;
    flag_set[FL_LOW]   = supply_low_evt;
    flag_set[FL_FAULT] = supply_high_evt || supply_low_evt;
    flag_set[FL_SHIFT0] = moved_evt[0];
    flag_set[FL_SHIFT1] = moved_evt[1];
    flag_set[FL_ZERO0]  = zero_found_evt[0];
    flag_set[FL_ZERO1]  = zero_found_evt[1];
    flag_set[FL_HEAT0]  = overheat_evt[0];
    flag_set[FL_HEAT1]  = overheat_evt[1];
  end

  gsr_flag_bank #(.W(FLAG_N)) u_flags (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .set  (flag_set),
    .clr  (flag_clr),
    .q    (flags)
  );

  // Pointer bits are live; latched flags ride beside them
  always_comb
  begin
    dev_word[15] = gauge1.heading;
    dev_word[14] = gauge0.heading;
    dev_word[13] = gauge1.home_side;
    dev_word[12] = gauge0.home_side;
    dev_word[11] = gauge1.off_target;
    dev_word[10] = gauge0.off_target;
    dev_word[9]  = flags[FL_HIGH];
    dev_word[8]  = flags[FL_LOW];
    dev_word[7]  = cal_fault;
    dev_word[6]  = flags[FL_FAULT];
    dev_word[5]  = flags[FL_SHIFT1];
    dev_word[4]  = flags[FL_SHIFT0];
    dev_word[3]  = gauge1.homing || flags[FL_ZERO1];
    dev_word[2]  = gauge0.homing || flags[FL_ZERO0];
    dev_word[1]  = flags[FL_HEAT1];
    dev_word[0]  = flags[FL_HEAT0];
  end

  always_comb
  begin
    case (status_select)
      4'h8, 4'h9, 4'ha, 4'hb:
        status_word = {rtz_active, rtz_acc};
      SEL_POS0:
        status_word = {gauge0.enabled, gauge0.heading,
                       gauge0.against_cmd, gauge0.off_target,
                       gauge0.position};
      SEL_POS1:
        status_word = {gauge1.enabled, gauge1.heading,
                       gauge1.against_cmd, gauge1.off_target,
                       gauge1.position};
      4'he, 4'hf:
        status_word = {gauge1.velocity, gauge0.velocity};
      default:
        status_word = dev_word;
    endcase
  end

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE  = 2'b11
  } gsr_state_t;

  gsr_state_t        state_reg;
  gsr_state_t        state_next;
  logic [15:0]       tx_reg;
  logic [15:0]       tx_next;
  logic [15:0]       rx_reg;
  logic [15:0]       rx_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic              any_reg;
  logic              any_next;
  logic              si_bit_reg;
  logic              si_bit_next;
  logic [FLAG_N-1:0] snap_reg;
  logic [FLAG_N-1:0] snap_next;
  logic [3:0]        sel_next;
  logic              len_ok;
  logic              sel_hit;

  assign len_ok  = any_reg && (cnt_reg == CNT_ZERO);
  assign sel_hit = rx_reg[15:CMD_ADDR_LSB] == SEL_CMD_ADDR;

  always_comb
  begin
    state_next  = state_reg;
    tx_next     = tx_reg;
    rx_next     = rx_reg;
    cnt_next    = cnt_reg;
    any_next    = any_reg;
    si_bit_next = si_bit_reg;
    snap_next   = snap_reg;
    sel_next    = status_select;
    if (ce)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (!cs_s)
          begin
            state_next = ST_SHIFT;
            tx_next    = status_word;
            cnt_next   = CNT_ZERO;
            any_next   = 1'b0;
            // Flags shown in this word may be cleared by it; the moved flags are cleared by any word
            snap_next  = flags;
            if (status_select[3])
            begin
              snap_next[FL_HIGH]  = 1'b0;
              snap_next[FL_LOW]   = 1'b0;
              snap_next[FL_FAULT] = 1'b0;
              snap_next[FL_ZERO0] = 1'b0;
              snap_next[FL_ZERO1] = 1'b0;
            end
          end
        end
        ST_SHIFT:
        begin
          if (cs_s)
            state_next = ST_DONE;
          else
          begin
            if (sclk_rise)
            begin
              rx_next     = {rx_reg[14:0], si_s};
              si_bit_next = si_s;
              cnt_next    = cnt_reg + 4'h1;
              any_next    = 1'b1;
            end
            // Received bits queue behind the status word
            if (sclk_fall && any_reg)
              tx_next = {tx_reg[14:0], si_bit_reg};
          end
        end
        ST_DONE:
        begin
          state_next = ST_IDLE;
          if (len_ok && sel_hit)
            sel_next = rx_reg[SEL_LSB+3:SEL_LSB];
        end
        default:
          state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg     <= ST_IDLE;
      tx_reg        <= WORD_ZERO;
      rx_reg        <= WORD_ZERO;
      cnt_reg       <= CNT_ZERO;
      any_reg       <= 1'b0;
      si_bit_reg    <= 1'b0;
      snap_reg      <= FLAGS_RESET;
      status_select <= SEL_RESET;
    end
    else
    begin
      state_reg     <= state_next;
      tx_reg        <= tx_next;
      rx_reg        <= rx_next;
      cnt_reg       <= cnt_next;
      any_reg       <= any_next;
      si_bit_reg    <= si_bit_next;
      snap_reg      <= snap_next;
      status_select <= sel_next;
    end
  end

  // ----------------------------------------------------------------
  // Frame results, flag clearing and driver shutdown
  // ----------------------------------------------------------------
  logic       off_next;
  logic [1:0] gauge_off_next;

  assign frame_strobe = ce && (state_reg == ST_DONE) && len_ok;
  assign frame_word   = rx_reg;
  assign so           = tx_reg[15];
  assign so_oe_n      = (state_reg != ST_SHIFT);

  always_comb
  begin
    // Bad length leaves every flag standing
    flag_clr = frame_strobe ? snap_reg : '0;
    flag_clr[FL_HEAT0] = gauge_reenable[0];
    flag_clr[FL_HEAT1] = gauge_reenable[1];
    flag_clr[FL_ZERO0] = flag_clr[FL_ZERO0] || return_home_off[0];
    flag_clr[FL_ZERO1] = flag_clr[FL_ZERO1] || return_home_off[1];
    off_next       = ce ? supply_high_evt : drivers_off;
    gauge_off_next = ce ? overheat_evt : gauge_off;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      drivers_off <= 1'b0;
      gauge_off   <= 2'b00;
    end
    else
    begin
      drivers_off <= off_next;
      gauge_off   <= gauge_off_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  load_msb_a : assert property (@(posedge clk) disable iff (!nrst)
    (ce && state_reg == ST_IDLE && !cs_s) |=> so == $past(status_word[15]))
    else $error("status word MSB not on output after select");

  accept_len_a : assert property (@(posedge clk) disable iff (!nrst)
    frame_strobe |-> (any_reg && cnt_reg == CNT_ZERO && $past(cs_s)
                      && $past(state_reg) == ST_SHIFT))
    else $error("frame accepted with bad length");

  so_float_a : assert property (@(posedge clk) disable iff (!nrst)
    (ce && cs_s && state_reg != ST_SHIFT) |=> so_oe_n)
    else $error("output driven while deselected");

  keep_faults_a : assert property (@(posedge clk) disable iff (!nrst)
    (state_reg == ST_DONE && !len_ok && gauge_reenable == 2'b00
     && return_home_off == 2'b00)
    |=> (flags & $past(flags)) == $past(flags))
    else $error("fault cleared by bad frame");

  echo_a : assert property (@(posedge clk) disable iff (!nrst)
    (sclk_fall && any_reg && state_reg == ST_SHIFT && !cs_s)
    |=> tx_reg[0] == $past(si_bit_reg))
    else $error("echo bit not queued");

  sel_hold_a : assert property (@(posedge clk) disable iff (!nrst)
    (status_select != $past(status_select)) |-> $past(frame_strobe))
    else $error("select changed without accepted frame");

  sel_reset_a : assert property (@(posedge clk)
    !nrst |=> status_select == SEL_RESET)
    else $error("select not defaulted by reset");

  dev_word_a : assert property (@(posedge clk) disable iff (!nrst)
    !status_select[3] |-> status_word == dev_word)
    else $error("device word not chosen");

  high_off_a : assert property (@(posedge clk) disable iff (!nrst)
    (ce && supply_high_evt) |=> (drivers_off && dev_word[9] && dev_word[6]))
    else $error("supply high not flagged or drivers on");

  low_on_a : assert property (@(posedge clk) disable iff (!nrst)
    (ce && supply_low_evt && !supply_high_evt) |=> (!drivers_off && dev_word[8]))
    else $error("supply low handled wrongly");

endmodule : gsr_status_readback
`default_nettype wire

// ---- sim/gsr_host.sv ----
// Host side of the serial link: mode 0 frames, MSB first, 400 ns sclk.
// Assumes the bench calls frame() from one process only.
`timescale 1ns/1ps
`default_nettype none
module gsr_host (
  // System clock
  input  wire logic clk,
  // Serial pins
  output var  logic cs_n,
  output var  logic sclk,
  output var  logic si,
  input  wire logic so,
  input  wire logic so_oe_n
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // ------------------------------------------------------------
  // One frame of n bits; ok drops if the output enable misbehaves
  // ------------------------------------------------------------
  task automatic frame(input int n, input logic [31:0] din,
                       output logic [31:0] dout, output logic ok);
    dout = '0;
    ok   = 1'b1;
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      si <= din[n-1-i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      dout = {dout[30:0], so};
      ok   = ok & (so_oe_n === 1'b0);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // Released line must not keep showing the last bit
    si   <= ~si;
    repeat (6) @(posedge clk);
    ok = ok & (so_oe_n === 1'b1);
  endtask : frame
endmodule : gsr_host
`default_nettype wire

// ---- sim/gsr_status_readback_tb.sv ----
// Bench for the status readback block: words, sticky flags, length
// checks, echo and select codes. Assumes gsr_host drives the pins.
`timescale 1ns/1ps
`default_nettype none
module gsr_status_readback_tb
  import gsr_pkg::*;
;
  localparam logic [15:0] NOP = 16'he000;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  gsr_gauge_t  gauge0 = 26'h2000000;
  gsr_gauge_t  gauge1 = 26'h0800000;
  logic [14:0] rtz_acc = 15'h5a3c;
  logic        rtz_active = 1'b1;
  logic        cal_fault = 1'b0;
  logic        supply_high_evt = 1'b0;
  logic        supply_low_evt = 1'b0;
  logic [1:0]  moved_evt = 2'h0;
  logic [1:0]  zero_found_evt = 2'h0;
  logic [1:0]  return_home_off = 2'h0;
  logic [1:0]  overheat_evt = 2'h0;
  logic [1:0]  gauge_reenable = 2'h0;
  logic        cs_n, sclk, si, so, so_oe_n;
  logic [15:0] frame_word;
  logic        frame_strobe;
  logic [3:0]  status_select;
  logic        drivers_off;
  logic [1:0]  gauge_off;
  int          fails = 0;
  int          samples_checked = 0;
  int          strobes = 0;

  always #25 clk = ~clk;

  always @(posedge clk)
    if (frame_strobe === 1'b1) strobes <= strobes + 1;

  gsr_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
                 .so_oe_n(so_oe_n));

  gsr_status_readback dut (
    .clk(clk), .nrst(nrst), .ce(ce), .cs_n(cs_n), .sclk(sclk), .si(si),
    .so(so), .so_oe_n(so_oe_n), .gauge0(gauge0), .gauge1(gauge1),
    .rtz_acc(rtz_acc), .rtz_active(rtz_active), .cal_fault(cal_fault),
    .supply_high_evt(supply_high_evt), .supply_low_evt(supply_low_evt),
    .moved_evt(moved_evt), .zero_found_evt(zero_found_evt),
    .return_home_off(return_home_off), .overheat_evt(overheat_evt),
    .gauge_reenable(gauge_reenable), .frame_word(frame_word),
    .frame_strobe(frame_strobe), .status_select(status_select),
    .drivers_off(drivers_off), .gauge_off(gauge_off));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rd(input int n, input logic [31:0] din, input int acc,
                    output logic [31:0] q);
    int   s0;
    logic ok;
    s0 = strobes;
    host.frame(n, din, q, ok);
    chk(16'(ok), 16'h1);
    chk(16'(strobes - s0), 16'(acc));
  endtask : rd

  // Device word from live inputs, sticky flags all clear
  function automatic logic [15:0] lw();
    return {gauge1.heading, gauge0.heading, gauge1.home_side,
            gauge0.home_side, gauge1.off_target, gauge0.off_target, 2'b00,
            cal_fault, 3'b000, gauge1.homing, gauge0.homing, 2'b00};
  endfunction : lw

  function automatic logic [15:0] pw(input gsr_gauge_t g);
    return {g.enabled, g.heading, g.against_cmd, g.off_target, g.position};
  endfunction : pw

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] q;
    chk(16'(status_select), 16'(SEL_RESET));
    chk(16'(so_oe_n), 16'h1);
    for (int k = 0; k < 2; k++)
    begin
      @(posedge clk);
      {gauge1.heading, gauge0.home_side, gauge1.off_target, cal_fault}
        <= {4{~k[0]}};
      {gauge0.heading, gauge1.home_side, gauge0.off_target} <= {3{k[0]}};
      rd(16, NOP, 1, q);
      chk(q[15:0], lw());
    end
    $display("t_reset done");
  endtask : t_reset

  task automatic t_supply;
    logic [31:0] q;
    @(posedge clk);
    supply_low_evt <= 1'b1;
    @(posedge clk);
    supply_low_evt <= 1'b0;
    #1;
    chk(16'(drivers_off), 16'h0);
    @(posedge clk);
    supply_high_evt <= 1'b1;
    @(posedge clk);
    supply_high_evt <= 1'b0;
    #1;
    chk(16'(drivers_off), 16'h1);
    rd(16, NOP, 1, q);
    chk(q[15:0], lw() | 16'h0340);
    rd(16, NOP, 1, q);
    chk(q[15:0], lw());
    @(posedge clk);
    gauge_reenable <= 2'b11;
    @(posedge clk);
    gauge_reenable <= 2'b00;
    $display("t_supply done");
  endtask : t_supply

  task automatic t_len;
    logic [31:0] q;
    @(posedge clk);
    supply_high_evt <= 1'b1;
    @(posedge clk);
    supply_high_evt <= 1'b0;
    // Seventeen bits ending in a select command must be ignored
    rd(17, 32'h00000c00, 0, q);
    chk(q[16:1], lw() | 16'h0240);
    chk(16'(status_select), 16'(SEL_RESET));
    rd(0, 32'h0, 0, q);
    rd(16, NOP, 1, q);
    chk(q[15:0], lw() | 16'h0240);
    rd(16, NOP, 1, q);
    chk(q[15:0], lw());
    $display("t_len done");
  endtask : t_len

  task automatic t_echo;
    logic [31:0] q;
    rd(32, {16'he123, 16'he456}, 1, q);
    chk(q[31:16], lw());
    chk(q[15:0], 16'he123);
    chk(frame_word, 16'he456);
    $display("t_echo done");
  endtask : t_echo

  task automatic t_sel;
    logic [3:0]  codes [8] = '{4'h5, 4'h8, 4'hb, 4'hc, 4'hd, 4'he, 4'hf,
                               4'h0};
    logic [31:0] q;
    logic [15:0] e;
    for (int i = 0; i < 8; i++)
    begin
      rd(16, {20'h0, codes[i], 8'h00}, 1, q);
      chk(16'(status_select), 16'(codes[i]));
      @(posedge clk);
      gauge0.position <= 12'h3a0 + 12'(i);
      gauge1.position <= 12'h5c0 - 12'(i);
      gauge0.velocity <= 8'h40 + 8'(i);
      gauge1.velocity <= 8'h90 - 8'(i);
      rtz_acc         <= 15'h1234 + 15'(i);
      rtz_active      <= i[0];
      @(posedge clk);
      if (!codes[i][3]) e = lw();
      else if (codes[i][3:2] == 2'b10) e = {rtz_active, rtz_acc};
      else if (codes[i] == SEL_POS0) e = pw(gauge0);
      else if (codes[i] == SEL_POS1) e = pw(gauge1);
      else e = {gauge1.velocity, gauge0.velocity};
      rd(16, NOP, 1, q);
      chk(q[15:0], e);
      chk(16'(status_select), 16'(codes[i]));
    end
    $display("t_sel done");
  endtask : t_sel

  task automatic t_rerun;
    logic [31:0] q;
    rd(16, {20'h0, 4'he, 8'h00}, 1, q);
    chk(16'(status_select), 16'he);
    @(posedge clk);
    moved_evt <= 2'b01;
    nrst      <= 1'b0;
    @(posedge clk);
    moved_evt <= 2'b00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(16'(status_select), 16'(SEL_RESET));
    rd(16, NOP, 1, q);
    chk(q[15:0], lw());
    $display("t_rerun done");
  endtask : t_rerun

  task automatic t_evt;
    logic [31:0] q;
    @(posedge clk);
    moved_evt <= 2'b10;
    @(posedge clk);
    moved_evt <= 2'b00;
    rd(16, NOP, 1, q);
    chk(q[15:0], lw() | 16'h0020);
    @(posedge clk);
    gauge1.homing <= 1'b1;
    rd(16, NOP, 1, q);
    chk(q[15:0], lw() | 16'h0008);
    @(posedge clk);
    zero_found_evt <= 2'b10;
    gauge1.homing  <= 1'b0;
    @(posedge clk);
    zero_found_evt <= 2'b00;
    rd(16, NOP, 1, q);
    chk(q[15:0], lw() | 16'h0008);
    @(posedge clk);
    zero_found_evt <= 2'b01;
    @(posedge clk);
    zero_found_evt  <= 2'b00;
    return_home_off <= 2'b01;
    @(posedge clk);
    return_home_off <= 2'b00;
    rd(16, NOP, 1, q);
    chk(q[15:0], lw());
    @(posedge clk);
    overheat_evt <= 2'b01;
    @(posedge clk);
    overheat_evt <= 2'b00;
    #1;
    chk(16'(gauge_off), 16'h1);
    for (int k = 0; k < 2; k++)
    begin
      rd(16, NOP, 1, q);
      chk(q[15:0], lw() | 16'h0001);
    end
    @(posedge clk);
    gauge_reenable <= 2'b01;
    @(posedge clk);
    gauge_reenable <= 2'b00;
    rd(16, NOP, 1, q);
    chk(q[15:0], lw());
    @(posedge clk);
    gauge0.homing <= 1'b1;
    rd(16, NOP, 1, q);
    chk(q[15:0], lw() | 16'h0004);
    $display("t_evt done");
  endtask : t_evt

  initial
  begin
    repeat (100000) @(posedge clk);
    fails++;
    final_report;
  end

  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_supply;
    t_len;
    t_echo;
    t_sel;
    t_rerun;
    t_evt;
    final_report;
  end
endmodule : gsr_status_readback_tb
`default_nettype wire
